/* File: rtl/dds_modulation_control.sv */
// Summary of operation
// - center alone when gate low, plus offset high
// - gate pin reaches output fourteen cycles later
// - gate path pipelined, toggles every cycle
// - one write strobe per eight-bit register
// - phase pins pipelined, toggles every cycle
// - control bit five low zeroes accumulator
// - phase pins add 0/90/180/270 degree offset
// - gate pin passes or zeroes offset word
// - gate, phase, update pins get synchronisers
`timescale 1ns/1ps
module dds_modulation_control
	import dds_mod_pkg::*;
(
	input wire logic I_CORE_CLK, // master clock, 10 MHz
	input wire logic I_RST_N, // synchronous reset, active low
	input wire logic I_OFFSET_FREQ_GATE_PIN, // high adds offset word
	input wire logic I_PHASE_SELECT_LSB, // phase select bit 0
	input wire logic I_PHASE_SELECT_MSB, // phase select bit 1
	input wire logic I_UPDATE, // master-to-active transfer pin
	input wire logic I_WR, // write strobe, one cycle per byte
	input wire logic I_WE_N, // write enable, active low
	input wire logic [3:0] I_ADDR, // register address
	input wire logic [7:0] I_DATA, // register data
	output logic [47:0] O_PHASE, // accumulator plus phase offset
	output logic [13:0] O_SAMPLE_PHASE // top bits fed to the sine lookup
);
	// ****************************************
	// parallel write port
	// ****************************************
	logic [47:0] center_master;
	logic [47:0] offset_master;
	logic [7:0] control_master;
	logic [47:0] center_word;
	logic [47:0] offset_word;
	logic [7:0] control_word;
	logic [SYNC_STAGES-1:0] sync_update;
	logic update_prev;
	wire write_hit = I_WR && !I_WE_N;
	wire update_pin_rise = sync_update[SYNC_STAGES-1] && !update_prev;
	wire update_reg_write = write_hit && (I_ADDR == ADDR_UPDATE);
	wire do_update = update_pin_rise || update_reg_write;

	// byte lane decode, used for both frequency words
	function automatic logic lane_hit(input logic [3:0] addr, input logic [3:0] base,
		input int idx);
		return addr == (base + idx[3:0]);
	endfunction : lane_hit

	// each strobe loads at most one byte of one master register
	genvar g;
	generate
		for (g = 0; g < NUM_BYTES; g++) begin : g_lane
			always_ff @(posedge I_CORE_CLK) begin
				if (!I_RST_N) begin
					center_master[g*REG_W +: REG_W] <= CENTER_RESET[g*REG_W +: REG_W];
					offset_master[g*REG_W +: REG_W] <= OFFSET_RESET[g*REG_W +: REG_W];
				end else if (write_hit) begin
					if (lane_hit(I_ADDR, ADDR_CENTER_BASE, g)) begin
						center_master[g*REG_W +: REG_W] <= I_DATA;
					end
					if (lane_hit(I_ADDR, ADDR_OFFSET_BASE, g)) begin
						offset_master[g*REG_W +: REG_W] <= I_DATA;
					end
				end
			end
		end
	endgenerate

	// control byte master copy; it goes live only on an update
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			control_master <= CTRL_RESET;
		end else if (write_hit && I_ADDR == ADDR_CONTROL) begin
			control_master <= I_DATA;
		end
	end

	// active copies; writes faster than clock/2 are the writer's problem
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			center_word <= CENTER_RESET;
			offset_word <= OFFSET_RESET;
			control_word <= CTRL_RESET;
		end else begin
			if (do_update) begin
				center_word <= center_master;
				offset_word <= offset_master;
				control_word <= control_master;
			end
		end
	end

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [SYNC_STAGES-1:0] sync_gate;
	logic [SYNC_STAGES-1:0] sync_ph0;
	logic [SYNC_STAGES-1:0] sync_ph1;

	// gate pin; the first stage is read only by the second
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			sync_gate <= '0;
		end else begin
			sync_gate <= {sync_gate[SYNC_STAGES-2:0], I_OFFSET_FREQ_GATE_PIN};
		end
	end

	// phase select low bit
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			sync_ph0 <= '0;
		end else begin
			sync_ph0 <= {sync_ph0[SYNC_STAGES-2:0], I_PHASE_SELECT_LSB};
		end
	end

	// phase select high bit
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			sync_ph1 <= '0;
		end else begin
			sync_ph1 <= {sync_ph1[SYNC_STAGES-2:0], I_PHASE_SELECT_MSB};
		end
	end

	// update pin
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			sync_update <= '0;
		end else begin
			sync_update <= {sync_update[SYNC_STAGES-2:0], I_UPDATE};
		end
	end

	// edge memory reads only the last stage; resets to the idle low level
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			update_prev <= 1'b0;
		end else begin
			update_prev <= sync_update[SYNC_STAGES-1];
		end
	end

	// ****************************************
	// pad pipeline, one bit per cycle so every toggle survives
	// ****************************************
	logic [PAD_STAGES-1:0] pad_gate;
	logic [PAD_STAGES-1:0] pad_ph0;
	logic [PAD_STAGES-1:0] pad_ph1;

	// a plain shift keeps order and allows a change on every edge
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			pad_gate <= '0;
		end else begin
			pad_gate <= {pad_gate[PAD_STAGES-2:0], sync_gate[SYNC_STAGES-1]};
		end
	end

	// phase low bit delay; costs flops but never drops a toggle
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			pad_ph0 <= '0;
		end else begin
			pad_ph0 <= {pad_ph0[PAD_STAGES-2:0], sync_ph0[SYNC_STAGES-1]};
		end
	end

	// phase high bit delay, kept in step with the low bit
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			pad_ph1 <= '0;
		end else begin
			pad_ph1 <= {pad_ph1[PAD_STAGES-2:0], sync_ph1[SYNC_STAGES-1]};
		end
	end

	// ****************************************
	// frequency word, accumulator and phase offset
	// ****************************************
	logic [47:0] step_word;
	logic [47:0] accum;
	logic [1:0] phase_sel_d;
	logic [1:0] phase_sel_q;
	wire gate_late = pad_gate[PAD_STAGES-1];
	wire acc_run = control_word[CTRL_ACC_RUN_BIT];
	wire [47:0] gated_offset = gate_late ? offset_word : '0;
	wire [47:0] next_step = center_word + gated_offset;
	wire [47:0] next_accum = acc_run ? accum + step_word : '0;
	wire [1:0] phase_sel = {pad_ph1[PAD_STAGES-1], pad_ph0[PAD_STAGES-1]};
	// quarter turns map straight onto the top two phase bits
	wire [47:0] phase_add = {phase_sel_q, {(ACC_W-2){1'b0}}};

	// stage 1: step word; stages 1 to 3 together match CORE_STAGES
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			step_word <= '0;
		end else begin
			step_word <= next_step;
		end
	end

	// stage 2: accumulate, or hold at zero while parked
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			accum <= '0;
		end else begin
			accum <= next_accum;
		end
	end

	// phase code delayed two cycles to line up with the accumulator
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			phase_sel_d <= '0;
			phase_sel_q <= '0;
		end else begin
			phase_sel_d <= phase_sel;
			phase_sel_q <= phase_sel_d;
		end
	end

	// stage 3: phase add; both outputs come from the same sum
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			O_PHASE <= '0;
			O_SAMPLE_PHASE <= '0;
		end else begin
			O_PHASE <= accum + phase_add;
			O_SAMPLE_PHASE <= next_sample(accum + phase_add);
		end
	end

	// top bits of a phase word
	function automatic logic [13:0] next_sample(input logic [47:0] p);
		return p[ACC_W-1 -: OUT_W];
	endfunction : next_sample
endmodule : dds_modulation_control

/* File: common/dds_mod_pkg.sv */
package dds_mod_pkg;
	// ****************************************
	// widths and layout
	// ****************************************
	localparam int ACC_W = 48;
	localparam int REG_W = 8;
	localparam int ADDR_W = 4;
	localparam int OUT_W = 14;
	localparam int NUM_BYTES = 6;
	// register addresses on the parallel port
	localparam logic [3:0] ADDR_CENTER_BASE = 4'h0;
	localparam logic [3:0] ADDR_OFFSET_BASE = 4'h6;
	localparam logic [3:0] ADDR_CONTROL = 4'hD;
	localparam logic [3:0] ADDR_UPDATE = 4'hF;
	// control bit that lets the accumulator run
	localparam int CTRL_ACC_RUN_BIT = 5;
	localparam logic [7:0] CTRL_RESET = 8'h20;
	// center word resets to a quarter of the clock rate
	localparam logic [47:0] CENTER_RESET = 48'h4000_0000_0000;
	localparam logic [47:0] OFFSET_RESET = 48'h0000_0000_0000;
	// ****************************************
	// timing
	// ****************************************
	// total pin-to-output delay in clock cycles
	localparam int PIN_LATENCY = 14;
	// two-stage pin synchroniser
	localparam int SYNC_STAGES = 2;
	// cycles from the end of the pad pipeline to the accumulator/phase stage output
	localparam int CORE_STAGES = 3;
	// padding so the total matches PIN_LATENCY
	localparam int PAD_STAGES = PIN_LATENCY - SYNC_STAGES - CORE_STAGES;
endpackage : dds_mod_pkg

/* File: verif/dds_mod_monitor.sv */
`timescale 1ns/1ps
module dds_mod_monitor (
	input wire logic I_CORE_CLK, I_RST_N, I_UPDATE, I_WR, I_WE_N,
	input wire logic I_OFFSET_FREQ_GATE_PIN, I_PHASE_SELECT_LSB, I_PHASE_SELECT_MSB,
	input wire logic [47:0] O_PHASE,
	input wire logic [13:0] O_SAMPLE_PHASE
);
	logic [47:0] p1, p2;
	logic [15:0] g, a, b;
	logic [4:0] q;
	// second difference is zero while step and phase code hold
	wire [47:0] dd = O_PHASE - (p1 << 1) + p2;
	wire [1:0] f13 = {b[13], a[13]}, f14 = {b[14], a[14]}, f15 = {b[15], a[15]};
	// writes reload the words, so checks wait them out
	wire quiet = q > 5'h17;
	wire flat = g[13] == g[14];
	always_ff @(posedge I_CORE_CLK) begin
		p1 <= O_PHASE;
		p2 <= p1;
		g <= {g[14:0], I_OFFSET_FREQ_GATE_PIN};
		a <= {a[14:0], I_PHASE_SELECT_LSB};
		b <= {b[14:0], I_PHASE_SELECT_MSB};
		q <= (!I_RST_N || I_UPDATE || (I_WR && !I_WE_N)) ? 5'h0 : q + {4'h0, q != 5'h1F};
	end
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);
	a_sample_top: assert property (O_SAMPLE_PHASE == O_PHASE[47:34]) else $error("top");
	a_reset_zero: assert property ($rose(I_RST_N) |-> O_PHASE == 48'h0) else $error("rst");
	a_first_edge: assert property ($rose(I_RST_N) |=> O_SAMPLE_PHASE == 14'h0) else $error("rel");
	a_steady_step: assert property (quiet && flat && f13 == f14 && f14 == f15 |-> dd == 48'h0)
		else $error("step");
	a_low_bits: assert property (quiet && flat |-> dd[45:0] == 46'h0) else $error("low");
	a_phase_jump: assert property (quiet && flat && f13 != f14 && f14 == f15 |-> dd[47:46] == f13 - f14)
		else $error("jump");
	a_phase_tail: assert property (quiet && flat && f13 == f14 && f14 != f15 |-> dd[47:46] == f15 - f14)
		else $error("tail");
	a_stop_hold: assert property (quiet && flat && g[12] == g[13] && O_PHASE[45:0] == 46'h0
		&& p1[45:0] == 46'h0 |=> O_PHASE[45:0] == 46'h0) else $error("hold");
	c_gate: cover property (quiet && !flat);
	c_jump: cover property (quiet && flat && f13 != f14);
	c_reset: cover property ($rose(I_RST_N));
endmodule : dds_mod_monitor
bind dds_modulation_control dds_mod_monitor mon (.*);

/* File: verif/dds_ctrl_model.sv */
`timescale 1ns/1ps
module dds_ctrl_model (
	input wire logic I_CORE_CLK, // clock
	output logic I_UPDATE, I_WR, I_WE_N, // bus control
	output logic [3:0] I_ADDR, // address
	output logic [7:0] I_DATA // data
);
	initial {I_UPDATE, I_WR, I_WE_N, I_ADDR, I_DATA} = 15'h1000;
	// a put spans two cycles, so one register is never hit faster
	task put(input logic [3:0] a, input logic [7:0] d);
		@(negedge I_CORE_CLK);
		{I_WR, I_WE_N, I_ADDR, I_DATA} = {2'b10, a, d};
		@(negedge I_CORE_CLK);
		{I_WR, I_WE_N, I_DATA} = {2'b01, ~d};
	endtask : put
endmodule : dds_ctrl_model

/* File: verif/tb_dds_modulation_control.sv */
`timescale 1ns/1ps
module tb_dds_modulation_control;
	import dds_mod_pkg::*;
	logic I_CORE_CLK = 1'b0, I_RST_N = 1'b0, I_OFFSET_FREQ_GATE_PIN = 1'b0;
	logic I_PHASE_SELECT_LSB = 1'b0, I_PHASE_SELECT_MSB = 1'b0, I_UPDATE, I_WR, I_WE_N;
	logic [3:0] I_ADDR;
	logic [7:0] I_DATA;
	logic [47:0] O_PHASE, last, dif;
	logic [13:0] O_SAMPLE_PHASE;
	logic [21:0] g = 22'h0;
	int error_cnt = 0, compares = 0;
	always #50 I_CORE_CLK = ~I_CORE_CLK;
	dds_ctrl_model m (.*);
	dds_modulation_control dut (.*);
	// step over the last cycle, taken mid-cycle
	task tick;
		@(negedge I_CORE_CLK);
		dif = O_PHASE - last;
		last = O_PHASE;
	endtask : tick
	task chk(input logic [47:0] s, input logic [47:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %0t saw %h want %h", $time, s, e);
		end
	endtask : chk
	task summarize;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	// gate toggled every two cycles; each toggle lands fourteen cycles on
	task t_fsk;
		m.put(4'h7, 8'h01);
		m.put(ADDR_UPDATE, 8'h00);
		repeat (24) tick();
		for (int j = 0; j < 22; j++) begin
			I_OFFSET_FREQ_GATE_PIN = j < 8 && !j[1];
			g[j] = I_OFFSET_FREQ_GATE_PIN;
			tick();
			if (j > 11)
				chk(dif, CENTER_RESET + ((j > 12 && g[j - 13]) ? 48'h100 : 48'h0));
		end
		$display("fsk done");
	endtask : t_fsk
	// every code step adds one quadrant
	task t_psk;
		for (int k = 1; k < 5; k++) begin
			{I_PHASE_SELECT_MSB, I_PHASE_SELECT_LSB} = k[1:0];
			repeat (14) tick();
			chk(dif, CENTER_RESET + 48'h4000_0000_0000);
		end
		$display("psk done");
	endtask : t_psk
	// park, then resume with a rewritten centre; the stray address is dropped
	task t_stop;
		m.put(ADDR_CONTROL, 8'h00);
		m.put(ADDR_UPDATE, 8'h00);
		repeat (8) tick();
		chk(O_PHASE, 48'h0);
		m.put(ADDR_CONTROL, CTRL_RESET);
		m.put(4'h5, 8'h10);
		m.put(4'h5, 8'h30);
		m.put(4'hC, 8'hFF);
		m.I_UPDATE = 1'b1;
		tick();
		m.I_UPDATE = 1'b0;
		repeat (10) tick();
		chk(dif, 48'h3000_0000_0000);
		$display("stop done");
	endtask : t_stop
	initial begin
		repeat (10) @(negedge I_CORE_CLK);
		I_RST_N = 1'b1;
		repeat (8) tick();
		chk(dif, CENTER_RESET);
		t_fsk();
		t_psk();
		t_stop();
		summarize();
	end
endmodule : tb_dds_modulation_control
